// ---- verilog/pst_cfg.svh ----
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// Lane count and field widths
`define PST_LANES        3'h4
`define PST_NLANES       4
`define PST_LANE_W       2
`define PST_AMP_W        4
`define PST_CNT_W        32
`define PST_RATE_W       16
`define PST_BITS_W       40
`define PST_LFSR_W       31
`define PST_LEN_W        5

// Feedback tap positions, zero based, for x^n + x^m + 1
`define PST_TAP7A        6
`define PST_TAP7B        5
`define PST_TAP11A       10
`define PST_TAP11B       8
`define PST_TAP23A       22
`define PST_TAP23B       17
`define PST_TAP31A       30
`define PST_TAP31B       27

// Sequence orders as lock lengths
`define PST_LEN7         5'h07
`define PST_LEN11        5'h0B
`define PST_LEN23        5'h17
`define PST_LEN31        5'h1F

// Reset values
`define PST_SEED         31'h7FFF_FFFF
`define PST_SEED_BIT     1'b1
`define PST_LFSR_ZERO    31'h0000_0000
`define PST_CNT_ZERO     32'h0000_0000
`define PST_CNT_ONE      32'h0000_0001
`define PST_CNT_MAX      32'hFFFF_FFFF
`define PST_BITS_ZERO    40'h00_0000_0000
`define PST_RATE_ZERO    16'h0000
`define PST_LEN_ZERO     5'h00
`define PST_LEN_ONE      5'h01
`define PST_AMP_RST      4'h0

// Timing: refresh interval of the error-rate figures
`define PST_SECOND_NS     32'h3B9A_CA00
`define PST_CLK_PERIOD_NS 32'h0000_0005
`define PST_SECOND_CYCLES (`PST_SECOND_NS / `PST_CLK_PERIOD_NS)

`endif

// ---- verilog/pst_pkg.sv ----
`include "pst_cfg.svh"

package pst_pkg;

  // Sequence order selection
  typedef enum logic [1:0] {
    PST_PRBS7,
    PST_PRBS11,
    PST_PRBS23,
    PST_PRBS31
  } pst_order_t;

  // Test engine state
  typedef enum logic {
    PST_IDLE,
    PST_RUN
  } pst_state_t;

  // Next sequence bit for the chosen order
  function automatic logic pst_fb(input logic [`PST_LFSR_W-1:0] s, input pst_order_t o);
    logic b;
    b = 1'b0;
    unique case (o)
      PST_PRBS7:  b = s[`PST_TAP7A] ^ s[`PST_TAP7B];
      PST_PRBS11: b = s[`PST_TAP11A] ^ s[`PST_TAP11B];
      PST_PRBS23: b = s[`PST_TAP23A] ^ s[`PST_TAP23B];
      PST_PRBS31: b = s[`PST_TAP31A] ^ s[`PST_TAP31B];
    endcase
    return b;
  endfunction

  // Bits needed to fill the register for the chosen order
  function automatic logic [`PST_LEN_W-1:0] pst_len(input pst_order_t o);
    logic [`PST_LEN_W-1:0] n;
    n = `PST_LEN7;
    unique case (o)
      PST_PRBS7:  n = `PST_LEN7;
      PST_PRBS11: n = `PST_LEN11;
      PST_PRBS23: n = `PST_LEN23;
      PST_PRBS31: n = `PST_LEN31;
    endcase
    return n;
  endfunction

endpackage

// ---- verilog/pst_prbs_gen.sv ----
`include "pst_cfg.svh"

module pst_prbs_gen (
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               clk_en_in,
  input  wire logic               restart_in,
  input  wire logic               run_in,
  input  wire pst_pkg::pst_order_t order_in,
  output logic                    bit_out
);
  import pst_pkg::*;

  logic [`PST_LFSR_W-1:0] lfsr;
  logic                   fb;

  // Feedback of the maximal-length polynomial
  assign fb = pst_fb(lfsr, order_in);

  // Shift register, one bit per enabled cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in || (clk_en_in && restart_in)) begin
      lfsr    <= `PST_SEED;
      bit_out <= `PST_SEED_BIT;  // Stream opens with the seed's newest bit
    end else if (clk_en_in && run_in) begin
      lfsr    <= {lfsr[`PST_LFSR_W-2:0], fb};
      bit_out <= fb;
    end
  end
endmodule

// ---- verilog/pst_prbs_chk.sv ----
`include "pst_cfg.svh"

module pst_prbs_chk (
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               clk_en_in,
  input  wire logic               restart_in,
  input  wire logic               run_in,
  input  wire pst_pkg::pst_order_t order_in,
  input  wire logic               rx_bit_in,
  output logic                    err_out,
  output logic                    synced_out
);
  import pst_pkg::*;

  logic [`PST_LFSR_W-1:0] lfsr;
  logic [`PST_LEN_W-1:0]  fill;
  logic                   expect_bit;
  logic                   fill_done;
  logic                   seed_bit;

  // Predicted bit and lock condition
  assign expect_bit = pst_fb(lfsr, order_in);
  assign fill_done  = (fill == pst_len(order_in) - `PST_LEN_ONE);

  // Seeding starts at the first one: the stream opens with a one after idle
  // zeros, so path latency never lands in the seed
  assign seed_bit   = (fill != `PST_LEN_ZERO) || rx_bit_in;

  // Seed from the received stream, then free-run on the prediction
  always_ff @(posedge core_clk_in) begin
    if (rst_in || (clk_en_in && restart_in)) begin
      lfsr       <= `PST_LFSR_ZERO;
      fill       <= `PST_LEN_ZERO;
      synced_out <= 1'b0;
      err_out    <= 1'b0;
    end else if (clk_en_in && run_in) begin
      if (!synced_out) begin
        lfsr    <= {lfsr[`PST_LFSR_W-2:0], rx_bit_in};
        err_out <= 1'b0;
        if (seed_bit) begin
          fill <= fill + `PST_LEN_ONE;
        end
        if (seed_bit && fill_done) begin
          synced_out <= 1'b1;
        end
      end else begin
        lfsr    <= {lfsr[`PST_LFSR_W-2:0], expect_bit};
        err_out <= rx_bit_in ^ expect_bit;
      end
    end else if (clk_en_in) begin
      err_out <= 1'b0;
    end
  end
endmodule

// ---- verilog/pst_lane_tester.sv ----
// How it works
// - Generator and checker run any of order 7, 11, 23 or 31 sequences.
// - Near-end loopback feeds generator bits to checker; transmit pin stays quiet.
// - Errors accumulate in a counter that starts at zero, cleared by reset request.
// - A lane flagged PCI Express forces the order-7 sequence.
// - Error rate is errors plus one over bits sent, rate times seconds.
// - While running, the rate figures refresh each second; no rate keeps default.
// - Stop returns default; reset idle keeps default; reset running restarts.
// - Staged amplitude settings reach a lane only at its soft reset.
// - On external coding lanes a reset to lane X resets only lane X.
// - On PCI Express any lane reset resets all link lanes and controller.
`include "pst_cfg.svh"

module pst_lane_tester #(
  parameter int unsigned SECOND_CYCLES = `PST_SECOND_CYCLES
) (
  input  wire logic                             core_clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             clk_en_in,
  input  wire logic                             start_in,
  input  wire logic                             stop_in,
  input  wire logic                             err_reset_in,
  input  wire logic [`PST_LANE_W-1:0]           lane_sel_in,
  input  wire pst_pkg::pst_order_t              order_sel_in,
  input  wire logic                             near_loop_in,
  input  wire logic [`PST_RATE_W-1:0]           data_rate_in,
  input  wire logic [`PST_NLANES-1:0]           lane_is_pcie_in,
  input  wire logic [`PST_NLANES-1:0]           lane_reset_req_in,
  input  wire logic                             amp_wr_in,
  input  wire logic [`PST_LANE_W-1:0]           amp_lane_in,
  input  wire logic [`PST_AMP_W-1:0]            amp_data_in,
  input  wire logic [`PST_NLANES-1:0]           rx_serial_in,
  output logic      [`PST_NLANES-1:0]           tx_serial_out,
  output logic                                  running_out,
  output logic                                  synced_out,
  output pst_pkg::pst_order_t                   order_active_out,
  output logic      [`PST_CNT_W-1:0]            err_count_out,
  output logic                                  ber_valid_out,
  output logic      [`PST_CNT_W-1:0]            ber_errs_out,
  output logic      [`PST_BITS_W-1:0]           ber_bits_out,
  output logic      [`PST_NLANES-1:0]           lane_rst_out,
  output logic                                  pcie_ctrl_rst_out,
  output logic      [`PST_NLANES*`PST_AMP_W-1:0] transmit_amplitude_setting_out
);
  import pst_pkg::*;

  pst_state_t                 state;
  pst_state_t                 next_state;
  pst_order_t                 order_run;
  logic [`PST_NLANES-1:0]     rx_s1;
  logic [`PST_NLANES-1:0]     rx_s2;
  logic [`PST_NLANES-1:0]     rx_s3;
  logic [`PST_NLANES-1:0]     rx_stable;
  logic [`PST_CNT_W-1:0]      sec_cnt;
  logic [`PST_BITS_W-1:0]     bits_acc;
  logic [`PST_AMP_W-1:0]      amp_stage [`PST_NLANES];
  logic                       gen_bit;
  logic                       chk_err;
  logic                       chk_synced;

  wire                        run          = (state == PST_RUN);
  wire                        go           = start_in && !run;
  wire                        halt         = stop_in && run;
  wire                        sel_pcie     = lane_is_pcie_in[lane_sel_in];
  wire                        sel_rst      = lane_rst_out[lane_sel_in];
  wire                        eng_restart  = go || (run && sel_rst);
  wire                        rate_given   = (data_rate_in != `PST_RATE_ZERO);
  wire                        sec_tick     = run && (sec_cnt == 32'(SECOND_CYCLES - 1));
  wire                        ber_restart  = go || halt || (err_reset_in && run) || !rate_given;
  wire                        rx_bit       = near_loop_in ? gen_bit : rx_stable[lane_sel_in];
  wire [`PST_NLANES-1:0]      pcie_req     = lane_reset_req_in & lane_is_pcie_in;
  wire                        any_pcie_req = |pcie_req;
  wire [`PST_NLANES-1:0]      next_lane_rst;
  wire [`PST_NLANES-1:0]      tx_drive;
  wire [`PST_CNT_W-1:0]       next_err_count;
  wire [`PST_BITS_W-1:0]      next_bits;
  pst_order_t                 next_order;
  pst_order_t                 next_active;

  // Order chosen at start; PCI Express lanes only offer order 7
  assign next_order = sel_pcie ? PST_PRBS7 : order_sel_in;

  // Order in use; a start shows its new order in the same cycle as running_out
  assign next_active = go ? next_order : order_run;

  // Start and stop sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      PST_IDLE: if (start_in) next_state = PST_RUN;
      PST_RUN:  if (stop_in) next_state = PST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state     <= PST_IDLE;
      order_run <= PST_PRBS7;
    end else if (clk_en_in) begin
      state <= next_state;
      if (go) begin
        order_run <= next_order;
      end
    end
  end

  // Pattern source
  pst_prbs_gen u_gen (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .restart_in  (eng_restart),
    .run_in      (run),
    .order_in    (order_run),
    .bit_out     (gen_bit)
  );

  // Pattern checker; near loopback takes the generator bit on die
  pst_prbs_chk u_chk (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .restart_in  (eng_restart),
    .run_in      (run),
    .order_in    (order_run),
    .rx_bit_in   (rx_bit),
    .err_out     (chk_err),
    .synced_out  (chk_synced)
  );

  // Receive pins: three stages and a retiming stage; a glitch vote would
  // swallow every lone bit of a one-bit-per-cycle stream, so none is applied
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_s1     <= '0;
      rx_s2     <= '0;
      rx_s3     <= '0;
      rx_stable <= '0;
    end else if (clk_en_in) begin
      rx_s1     <= rx_serial_in;
      rx_s2     <= rx_s1;
      rx_s3     <= rx_s2;
      rx_stable <= rx_s3;
    end
  end

  // Only the tested lane drives, and not in near loopback
  genvar gl;
  generate
    for (gl = 0; gl < `PST_NLANES; gl++) begin : g_tx
      assign tx_drive[gl] = run && !near_loop_in && (lane_sel_in == gl);
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_serial_out <= '0;
    end else if (clk_en_in) begin
      tx_serial_out <= tx_drive & {`PST_NLANES{gen_bit}};
    end
  end

  // Cumulative error count, saturating; the clear request wins
  assign next_err_count = (err_count_out == `PST_CNT_MAX) ? err_count_out
                                                          : err_count_out + `PST_CNT_ONE;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      err_count_out <= `PST_CNT_ZERO;
    end else if (clk_en_in) begin
      if (err_reset_in) begin
        err_count_out <= `PST_CNT_ZERO;
      end else if (run && chk_synced && chk_err) begin
        err_count_out <= next_err_count;
      end
    end
  end

  // Bits sent grows by the rate each second
  assign next_bits = bits_acc + {{(`PST_BITS_W-`PST_RATE_W){1'b0}}, data_rate_in};

  // Second counter runs only during a test; any restart begins a fresh second
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sec_cnt <= `PST_CNT_ZERO;
    end else if (clk_en_in) begin
      if (ber_restart || sec_tick) begin
        sec_cnt <= `PST_CNT_ZERO;
      end else if (run) begin
        sec_cnt <= sec_cnt + `PST_CNT_ONE;
      end
    end
  end

  // Bits sent so far in this rate calculation
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      bits_acc <= `PST_BITS_ZERO;
    end else if (clk_en_in) begin
      if (ber_restart) begin
        bits_acc <= `PST_BITS_ZERO;
      end else if (sec_tick) begin
        bits_acc <= next_bits;
      end
    end
  end

  // Figures change only on a whole second, so software never reads a partial
  // second; any restart falls back to the not-available default
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ber_valid_out <= 1'b0;
      ber_errs_out  <= `PST_CNT_ZERO;
      ber_bits_out  <= `PST_BITS_ZERO;
    end else if (clk_en_in) begin
      if (ber_restart) begin
        ber_valid_out <= 1'b0;
        ber_errs_out  <= `PST_CNT_ZERO;
        ber_bits_out  <= `PST_BITS_ZERO;
      end else if (sec_tick) begin
        ber_valid_out <= 1'b1;
        ber_errs_out  <= next_err_count;
        ber_bits_out  <= next_bits;
      end
    end
  end

  // Reset scope: single lane for external coding, whole link for PCI Express
  assign next_lane_rst = (lane_reset_req_in & ~lane_is_pcie_in)
                       | ({`PST_NLANES{any_pcie_req}} & lane_is_pcie_in);

  // Lane pulses last as long as the request; a held request keeps lanes in reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lane_rst_out <= '0;
    end else if (clk_en_in) begin
      lane_rst_out <= next_lane_rst;
    end
  end

  // Controller reset follows any request on a PCI Express lane
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pcie_ctrl_rst_out <= 1'b0;
    end else if (clk_en_in) begin
      pcie_ctrl_rst_out <= any_pcie_req;
    end
  end

  // Amplitude settings are staged, then applied by the lane soft reset
  generate
    for (gl = 0; gl < `PST_NLANES; gl++) begin : g_amp
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          amp_stage[gl]                                        <= `PST_AMP_RST;
          transmit_amplitude_setting_out[gl*`PST_AMP_W +: `PST_AMP_W] <= `PST_AMP_RST;
        end else if (clk_en_in) begin
          if (amp_wr_in && (amp_lane_in == gl)) begin
            amp_stage[gl] <= amp_data_in;
          end
          if (next_lane_rst[gl]) begin
            transmit_amplitude_setting_out[gl*`PST_AMP_W +: `PST_AMP_W] <= amp_stage[gl];
          end
        end
      end
    end
  endgenerate

  // Status outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      running_out      <= 1'b0;
      synced_out       <= 1'b0;
      order_active_out <= PST_PRBS7;
    end else if (clk_en_in) begin
      running_out      <= (next_state == PST_RUN);
      synced_out       <= chk_synced && run;
      order_active_out <= next_active;
    end
  end
endmodule

// ---- sim/pst_lane_tester_asserts.sv ----
`include "pst_cfg.svh"

module pst_lane_tester_asserts (
  input wire logic                                 core_clk_in,
  input wire logic                                 rst_in,
  input wire logic                                 clk_en_in,
  input wire logic                                 start_in,
  input wire logic                                 stop_in,
  input wire logic                                 err_reset_in,
  input wire logic [`PST_LANE_W-1:0]               lane_sel_in,
  input wire logic                                 near_loop_in,
  input wire logic [`PST_RATE_W-1:0]               data_rate_in,
  input wire logic [`PST_NLANES-1:0]               lane_is_pcie_in,
  input wire logic [`PST_NLANES-1:0]               lane_reset_req_in,
  input wire logic [`PST_NLANES-1:0]               tx_serial_out,
  input wire logic                                 running_out,
  input wire pst_pkg::pst_order_t                  order_active_out,
  input wire logic [`PST_CNT_W-1:0]                err_count_out,
  input wire logic                                 ber_valid_out,
  input wire logic [`PST_BITS_W-1:0]               ber_bits_out,
  input wire logic [`PST_NLANES-1:0]               lane_rst_out,
  input wire logic                                 pcie_ctrl_rst_out,
  input wire logic [`PST_NLANES*`PST_AMP_W-1:0]    transmit_amplitude_setting_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // Accepted start and stop commands
  sequence start_taken;
    clk_en_in && start_in && !running_out;
  endsequence
  sequence stop_taken;
    clk_en_in && stop_in && !start_in && running_out;
  endsequence

  start_run_a: assert property (start_taken |=> running_out)
    else $error("start did not begin a run");
  pcie_order_a: assert property (start_taken and lane_is_pcie_in[lane_sel_in] |=>
    order_active_out == PST_PRBS7) else $error("pcie lane ran a long sequence");
  near_quiet_a: assert property (near_loop_in && $past(near_loop_in) && $past(clk_en_in)
    |-> tx_serial_out == 4'h0) else $error("transmit pins active in loopback");
  err_clear_a: assert property (clk_en_in && err_reset_in |=>
    err_count_out == 32'h0000_0000) else $error("error count not cleared");
  ber_bits_a: assert property (ber_valid_out && $changed(ber_bits_out) |->
    ber_bits_out == $past(ber_bits_out) + 40'($past(data_rate_in)))
    else $error("bits sent did not grow by the rate");
  rate_absent_a: assert property (clk_en_in && data_rate_in == 16'h0000 |=>
    !ber_valid_out) else $error("error rate valid without a rate");
  stop_default_a: assert property (stop_taken |=> !running_out && !ber_valid_out)
    else $error("stop left the error rate valid");
  amp_on_reset_a: assert property ($changed(transmit_amplitude_setting_out) |->
    |lane_rst_out) else $error("amplitude changed without lane reset");
  lane_alone_a: assert property (clk_en_in && $onehot(lane_reset_req_in) &&
    lane_is_pcie_in == 4'h0 |=> lane_rst_out == $past(lane_reset_req_in) && !pcie_ctrl_rst_out)
    else $error("lane reset reached other lanes");
  pcie_all_a: assert property (clk_en_in && |(lane_reset_req_in & lane_is_pcie_in) |=>
    pcie_ctrl_rst_out && (lane_rst_out & $past(lane_is_pcie_in)) == $past(lane_is_pcie_in))
    else $error("pcie reset did not reach the whole link");
endmodule

bind pst_lane_tester pst_lane_tester_asserts u_pst_lane_tester_asserts (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .start_in(start_in),
  .stop_in(stop_in), .err_reset_in(err_reset_in), .lane_sel_in(lane_sel_in),
  .near_loop_in(near_loop_in), .data_rate_in(data_rate_in), .lane_is_pcie_in(lane_is_pcie_in),
  .lane_reset_req_in(lane_reset_req_in), .tx_serial_out(tx_serial_out),
  .running_out(running_out), .order_active_out(order_active_out),
  .err_count_out(err_count_out), .ber_valid_out(ber_valid_out), .ber_bits_out(ber_bits_out),
  .lane_rst_out(lane_rst_out), .pcie_ctrl_rst_out(pcie_ctrl_rst_out),
  .transmit_amplitude_setting_out(transmit_amplitude_setting_out));

// ---- sim/pst_chan_model.sv ----
`include "pst_cfg.svh"

module pst_chan_model (
  input  wire logic                   core_clk_in,
  input  wire logic [`PST_NLANES-1:0] tx_in,
  input  wire logic                   flip_in,
  output logic      [`PST_NLANES-1:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Cable path back to the receive pins; flip corrupts bits in flight
  initial rx_out = 4'h0;
  always @(posedge core_clk_in) begin
    rx_out <= tx_in ^ {`PST_NLANES{flip_in}};
  end
endmodule

// ---- sim/pst_lane_tester_tb_top.sv ----
`include "pst_cfg.svh"

module pst_lane_tester_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;

  logic                core_clk_in, rst_in, clk_en_in, near_loop_in, amp_wr_in, flip_in;
  logic                synced_out, running_out, ber_valid_out, pcie_ctrl_rst_out;
  logic [2:0]          cmd;
  logic [1:0]          lane_sel_in, amp_lane_in;
  logic [3:0]          amp_data_in, lane_is_pcie_in, lane_reset_req_in, rx_serial_in;
  logic [3:0]          tx_serial_out, lane_rst_out;
  logic [15:0]         data_rate_in, amp_out;
  logic [31:0]         err_count_out, ber_errs_out;
  logic [39:0]         ber_bits_out;
  pst_order_t          order_sel_in, order_active_out;
  int                  bad_count, compares;

  // Command bits: start, stop, error clear
  localparam logic [2:0] START = 3'h1, STOP = 3'h2, CLR = 3'h4;

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  pst_lane_tester #(.SECOND_CYCLES(50)) u_pst_lane_tester (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .start_in(cmd[0]),
    .stop_in(cmd[1]), .err_reset_in(cmd[2]), .lane_sel_in(lane_sel_in),
    .order_sel_in(order_sel_in), .near_loop_in(near_loop_in), .data_rate_in(data_rate_in),
    .lane_is_pcie_in(lane_is_pcie_in), .lane_reset_req_in(lane_reset_req_in),
    .amp_wr_in(amp_wr_in), .amp_lane_in(amp_lane_in), .amp_data_in(amp_data_in),
    .rx_serial_in(rx_serial_in), .tx_serial_out(tx_serial_out), .running_out(running_out),
    .synced_out(synced_out), .order_active_out(order_active_out),
    .err_count_out(err_count_out), .ber_valid_out(ber_valid_out), .ber_errs_out(ber_errs_out),
    .ber_bits_out(ber_bits_out), .lane_rst_out(lane_rst_out),
    .pcie_ctrl_rst_out(pcie_ctrl_rst_out), .transmit_amplitude_setting_out(amp_out));

  pst_chan_model u_pst_chan_model (
    .core_clk_in(core_clk_in), .tx_in(tx_serial_out), .flip_in(flip_in), .rx_out(rx_serial_in));

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic expect_eq(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // One-cycle command pulse; returns with the answer settled
  task automatic pulse(input logic [2:0] c);
    @(posedge core_clk_in);
    cmd <= c;
    @(posedge core_clk_in);
    cmd <= 3'h0;
    #1;
  endtask

  task automatic lane_req(input logic [3:0] r);
    @(posedge core_clk_in);
    lane_reset_req_in <= r;
    @(posedge core_clk_in);
    lane_reset_req_in <= 4'h0;
    #1;
  endtask

  // Bounded wait: 0 for lock, 1 for a valid error rate
  task automatic wait_for(input int which);
    for (int i = 0; i < 400; i++) begin
      if ((which == 0 ? synced_out : ber_valid_out) === 1'b1) return;
      tick(1);
    end
    bad_count++;
    $display("mismatch at %0t: wait %0d expired", $time, which);
    tally_and_finish;
  endtask

  // Every order locks cleanly over the on-die loop
  task automatic run_orders;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      order_sel_in <= pst_order_t'(k);
      pulse(START);
      expect_eq(running_out, 1'b1);
      expect_eq(order_active_out, pst_order_t'(k));
      wait_for(0);
      tick(64);
      expect_eq(err_count_out, 32'h0000_0000);
      expect_eq(tx_serial_out, 4'h0);
      pulse(STOP);
      expect_eq(running_out, 1'b0);
    end
  endtask

  // Off-die run with injected errors and the error-rate figures
  task automatic run_offdie;
    @(posedge core_clk_in);
    near_loop_in <= 1'b0;
    order_sel_in <= PST_PRBS23;
    lane_sel_in <= 2'h2;
    data_rate_in <= 16'h000A;
    pulse(START);
    wait_for(0);
    tick(20);
    expect_eq(err_count_out, 32'h0000_0000);
    @(posedge core_clk_in);
    flip_in <= 1'b1;
    @(posedge core_clk_in);
    flip_in <= 1'b0;
    tick(20);
    expect_eq(err_count_out != 32'h0000_0000, 1'b1);
    // Let the second refresh pass, so the figures include the injected error
    tick(40);
    wait_for(1);
    expect_eq(ber_bits_out, 40'h00_0000_0014);
    expect_eq(ber_errs_out, err_count_out + 32'h0000_0001);
    pulse(CLR);
    expect_eq(err_count_out, 32'h0000_0000);
    expect_eq(ber_valid_out, 1'b0);
    wait_for(1);
    expect_eq(ber_errs_out, 32'h0000_0001);
    @(posedge core_clk_in);
    data_rate_in <= 16'h0000;
    tick(120);
    expect_eq(ber_valid_out, 1'b0);
    @(posedge core_clk_in);
    data_rate_in <= 16'h000A;
    wait_for(1);
    pulse(STOP);
    expect_eq(ber_valid_out, 1'b0);
    pulse(CLR);
    tick(60);
    expect_eq(ber_valid_out, 1'b0);
  endtask

  // A PCI Express lane falls back to the order-7 sequence
  task automatic run_pcie_order;
    @(posedge core_clk_in);
    near_loop_in <= 1'b1;
    lane_is_pcie_in <= 4'h1;
    lane_sel_in <= 2'h0;
    order_sel_in <= PST_PRBS31;
    pulse(START);
    expect_eq(order_active_out, PST_PRBS7);
    pulse(STOP);
  endtask

  // Staged amplitude and soft reset scope
  task automatic run_lane_resets;
    @(posedge core_clk_in);
    lane_is_pcie_in <= 4'h0;
    amp_wr_in <= 1'b1;
    amp_lane_in <= 2'h1;
    amp_data_in <= 4'h5;
    @(posedge core_clk_in);
    amp_wr_in <= 1'b0;
    tick(3);
    expect_eq(amp_out, 16'h0000);
    for (int x = 0; x < 4; x++) begin
      lane_req(4'h1 << x);
      expect_eq({pcie_ctrl_rst_out, lane_rst_out}, 5'h01 << x);
      tick(1);
      expect_eq(lane_rst_out, 4'h0);
    end
    expect_eq(amp_out, 16'h0050);
    @(posedge core_clk_in);
    lane_is_pcie_in <= 4'h3;
    lane_req(4'h1);
    expect_eq({pcie_ctrl_rst_out, lane_rst_out}, 5'h13);
    lane_req(4'h8);
    expect_eq({pcie_ctrl_rst_out, lane_rst_out}, 5'h08);
  endtask

  initial begin
    {rst_in, clk_en_in, near_loop_in} = 3'h7;
    {amp_wr_in, flip_in, cmd} = 5'h00;
    {lane_sel_in, amp_lane_in, amp_data_in} = 8'h00;
    {lane_is_pcie_in, lane_reset_req_in, data_rate_in} = 24'h00_0000;
    order_sel_in = PST_PRBS7;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    run_orders;
    run_offdie;
    run_pcie_order;
    run_lane_resets;
    tally_and_finish;
  end
endmodule
